// ==== rtl/fdl_link_ctrl.sv ====
// Packet and bit-oriented code controller for the facility data link.
// Assumes the framer strobes one link bit per strobe on SYS_CLK and
// that host-side control ports are driven from the same clock.
// Operation
// RULE1 - Engine makes flags, checksum, aborts, stuffing and byte alignment.
// RULE2 - Each direction owns its own sixteen byte packet buffer.
// RULE3 - Code detector signals the host on arrival and on loss.
// RULE4 - Host loads a six-bit code, then sets send; device transmits it.
// RULE5 - Latched status bit sets on event, holds until read clears it.
// RULE6 - Real-time bits show present state; status writes leave them.
// RULE7 - Mask bit one loads read value from latch and clears latch.
// RULE8 - Mask bit zero keeps the previously captured read value.
// RULE9 - Host writes mask, reads at once, writes back masked result.
// RULE10 - Masked-in link events pull the active-low interrupt low.
// RULE11 - Interrupt releases once causing bits are read, none pending.
// RULE12 - Host picks this controller as source and sets its enable.
// RULE13 - Host disables legacy link controls before using this engine.
// RULE14 - On code change host checks presence, reads code or re-arms.
// RULE15 - Receive status gives empty, opening, closing and good per byte.
// RULE16 - Host drops packet when good flag is zero at closing byte.
// RULE17 - Host starts new packet only when transmit buffer is empty.
// RULE18 - Host fills while not full; marks the last byte before write.
// RULE19 - Message done event, then host checks the underrun status.
// RULE20 - Rising edge of receive reset control resets receive packet path.
// RULE21 - Rising edge of abort empties buffer, sends one abort byte.
// RULE22 - Checksum is the sixteen-bit frame check, x16+x12+x5+1.
`timescale 1ns/1ps
`default_nettype none
`include "fdl_cfg.svh"

module fdl_link_ctrl (
  input  wire logic       SYS_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       CODE_RESET_BIT,
  input  wire logic       RX_PACKET_RESET_BIT,
  input  wire logic       TX_RESET_BIT,
  input  wire logic       ABORT_SEND_BIT,
  input  wire logic       IDLE_SELECT,
  input  wire logic       LAST_BYTE_MARK,
  input  wire logic       STUFF_DISABLE,
  input  wire logic       CRC_DISABLE,
  input  wire logic       CTRL_ENABLE,
  input  wire logic [5:0] TX_CODE,
  input  wire logic       SEND_CODE_BIT,
  input  wire logic       STAT_WR,
  input  wire logic [1:0] STAT_SEL,
  input  wire logic [7:0] STAT_MASK,
  input  wire logic [7:0] EVENT_MASK,
  output logic      [7:0] LINK_EVENT_RD,
  output logic      [7:0] RX_STATUS_RD,
  output logic      [7:0] TX_STATUS_RD,
  output logic      [7:0] RX_CODE_RD,
  output logic            INT_N,
  input  wire logic       TX_WR,
  input  wire logic [7:0] TX_WR_DATA,
  output logic            TX_READY,
  input  wire logic       RX_RD,
  output logic      [7:0] RX_DATA,
  output logic            RX_VALID,
  input  wire logic       FDL_TX_STROBE,
  output logic            FDL_TX_BIT,
  input  wire logic       FDL_RX_STROBE,
  input  wire logic       FDL_RX_BIT
);
  import fdl_pkg::*;

  // ****************************************************************
  // Checksum helpers
  // ****************************************************************
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic b);
    crc_step = {1'b0, c[15:1]} ^ ((c[0] ^ b) ? `CRC_POLY : 16'h0000);
  endfunction : crc_step

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) r = crc_step(r, d[i]);
    crc_byte = r;
  endfunction : crc_byte

  // ****************************************************************
  // Control edges
  // ****************************************************************
  logic [3:0] ctl_q_reg;
  logic [3:0] ctl_now;
  logic [3:0] ctl_rise;
  logic       code_rst;
  logic       rx_rst;
  logic       tx_rst;
  logic       abort_rise;

  // Resets and abort act only on a zero-to-one step of their control
  assign ctl_now = {CODE_RESET_BIT, RX_PACKET_RESET_BIT, TX_RESET_BIT,
                    ABORT_SEND_BIT};
  assign ctl_rise = ctl_now & ~ctl_q_reg;
  assign code_rst = ctl_rise[3];
  assign rx_rst = ctl_rise[2];       // see RULE20
  assign tx_rst = ctl_rise[1];
  assign abort_rise = ctl_rise[0];   // see RULE21

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) ctl_q_reg <= 4'h0;
    else ctl_q_reg <= ctl_now;
  end

  // ****************************************************************
  // Buffers
  // ****************************************************************
  tx_entry_t  tx_in;
  tx_entry_t  tx_head;
  rx_entry_t  rx_push_data_reg;
  rx_entry_t  rx_head;
  logic       tx_valid;
  logic       tx_pop;
  logic       rx_push_reg;
  logic       rx_room;
  logic [4:0] tx_count;
  logic [4:0] rx_count;

  assign tx_in = '{last: LAST_BYTE_MARK, data: TX_WR_DATA};

  // Abort dumps whatever is queued; see RULE21
  fdl_byte_fifo #(.W($bits(tx_entry_t)), .DEPTH(`FIFO_DEPTH)) u_tx_fifo (
    .clk       (SYS_CLK),
    .rst       (SYS_RST),
    .flush     (tx_rst || abort_rise),
    .in_valid  (TX_WR),
    .in_ready  (TX_READY),
    .in_data   (tx_in),
    .out_valid (tx_valid),
    .out_ready (tx_pop),
    .out_data  (tx_head),
    .count     (tx_count)
  );  // see RULE2

  // A full receive buffer drops arriving bytes; the host must keep up
  fdl_byte_fifo #(.W($bits(rx_entry_t)), .DEPTH(`FIFO_DEPTH)) u_rx_fifo (
    .clk       (SYS_CLK),
    .rst       (SYS_RST),
    .flush     (rx_rst),
    .in_valid  (rx_push_reg),
    .in_ready  (rx_room),
    .in_data   (rx_push_data_reg),
    .out_valid (RX_VALID),
    .out_ready (RX_RD),
    .out_data  (rx_head),
    .count     (rx_count)
  );  // see RULE2

  assign RX_DATA = rx_head.data;

  // ****************************************************************
  // Transmit bit engine
  // ****************************************************************
  tx_state_t   tx_state_reg;
  tx_state_t   st_next;
  logic [7:0]  tx_sr_reg;
  logic [2:0]  tx_cnt_reg;
  logic [2:0]  tx_ones_reg;
  logic        tx_stuffable_reg;
  logic        tx_prev_stuff_reg;
  logic        tx_crc_en_reg;
  logic        tx_last_reg;
  logic        tx_boc_hi_reg;
  logic        abort_pend_reg;
  logic [15:0] tx_crc_reg;
  logic [15:0] crc_bit;
  logic [7:0]  tx_crc_hi_reg;
  logic        stuff_now;
  logic        shift_now;
  logic        byte_end;
  logic [7:0]  ld_byte;
  logic        ld_stuff;
  logic        ld_crc;
  logic        pop_c;
  logic        crc_init;
  logic        underrun_c;
  logic        done_c;
  logic        boc_next;
  logic        last_next;

  // Stuff after five ones, also across the boundary into a flag
  assign stuff_now = FDL_TX_STROBE && !STUFF_DISABLE && tx_ones_reg == 3'h5
                     && (tx_stuffable_reg
                         || (tx_cnt_reg == 3'h0 && tx_prev_stuff_reg));
  assign shift_now = FDL_TX_STROBE && !stuff_now;
  assign byte_end = shift_now && tx_cnt_reg == 3'h7;
  assign crc_bit = crc_step(tx_crc_reg, tx_sr_reg[0]);
  assign tx_pop = byte_end && pop_c;

  // Choice of the next line byte at each byte boundary
  always_comb begin
    ld_byte = IDLE_SELECT ? `IDLE_BYTE : `FLAG_BYTE;
    ld_stuff = 1'b0;
    ld_crc = 1'b0;
    st_next = tx_state_reg;
    pop_c = 1'b0;
    crc_init = 1'b0;
    underrun_c = 1'b0;
    done_c = 1'b0;
    boc_next = 1'b0;
    last_next = tx_last_reg;
    if (abort_pend_reg) begin
      ld_byte = `ABORT_BYTE;                          // see RULE21
      st_next = TX_IDLE;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (!CTRL_ENABLE) begin
            ld_byte = `IDLE_BYTE;
          end else if (tx_valid) begin
            ld_byte = `FLAG_BYTE;                     // see RULE1
            st_next = TX_OPEN;
          end else if (SEND_CODE_BIT || tx_boc_hi_reg) begin
            ld_byte = tx_boc_hi_reg ? {1'b0, TX_CODE, 1'b0}
                                    : `CODE_ONES;     // see RULE4
            boc_next = !tx_boc_hi_reg;
          end
        end
        TX_OPEN: begin
          ld_byte = tx_head.data;
          ld_stuff = 1'b1;
          ld_crc = 1'b1;
          crc_init = 1'b1;
          pop_c = 1'b1;
          last_next = tx_head.last;
          st_next = TX_DATA;
        end
        TX_DATA: begin
          if (tx_last_reg && CRC_DISABLE) begin
            ld_byte = `FLAG_BYTE;                     // see RULE18
            done_c = 1'b1;
            st_next = TX_IDLE;
          end else if (tx_last_reg) begin
            ld_byte = ~crc_bit[7:0];                  // see RULE22
            ld_stuff = 1'b1;
            st_next = TX_CRC_HI;
          end else if (tx_valid) begin
            ld_byte = tx_head.data;
            ld_stuff = 1'b1;
            ld_crc = 1'b1;
            pop_c = 1'b1;
            last_next = tx_head.last;
          end else begin
            ld_byte = `ABORT_BYTE;                    // see RULE19
            underrun_c = 1'b1;
            st_next = TX_IDLE;
          end
        end
        TX_CRC_HI: begin
          ld_byte = tx_crc_hi_reg;
          ld_stuff = 1'b1;
          st_next = TX_CLOSE;
        end
        TX_CLOSE: begin
          ld_byte = `FLAG_BYTE;
          done_c = 1'b1;
          st_next = TX_IDLE;
        end
        default: st_next = TX_IDLE;
      endcase
    end
  end

  // Shifter, stuffer and sequencer, LSB first on the line
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || tx_rst) begin
      tx_state_reg <= TX_IDLE;
      tx_sr_reg <= `IDLE_BYTE;
      tx_cnt_reg <= 3'h0;
      tx_ones_reg <= 3'h0;
      tx_stuffable_reg <= 1'b0;
      tx_prev_stuff_reg <= 1'b0;
      tx_crc_en_reg <= 1'b0;
      tx_last_reg <= 1'b0;
      tx_boc_hi_reg <= 1'b0;
      FDL_TX_BIT <= 1'b1;
    end else if (stuff_now) begin
      FDL_TX_BIT <= 1'b0;                             // see RULE1
      tx_ones_reg <= 3'h0;
    end else if (shift_now) begin
      FDL_TX_BIT <= tx_sr_reg[0];
      tx_ones_reg <= !tx_sr_reg[0] ? 3'h0 :
                     (tx_ones_reg == 3'h7) ? 3'h7 : tx_ones_reg + 3'h1;
      tx_cnt_reg <= tx_cnt_reg + 3'h1;
      if (byte_end) begin
        tx_sr_reg <= ld_byte;
        tx_stuffable_reg <= ld_stuff;
        tx_prev_stuff_reg <= tx_stuffable_reg;
        tx_crc_en_reg <= ld_crc;
        tx_state_reg <= st_next;
        tx_last_reg <= last_next;
        tx_boc_hi_reg <= boc_next;
      end else begin
        tx_sr_reg <= {1'b0, tx_sr_reg[7:1]};
      end
    end
  end

  // Running checksum over data bits only; stuffed zeros excluded
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || tx_rst) begin
      tx_crc_reg <= `CRC_INIT;
      tx_crc_hi_reg <= 8'h00;
    end else if (byte_end && crc_init) begin
      tx_crc_reg <= `CRC_INIT;
    end else if (shift_now && tx_crc_en_reg) begin
      tx_crc_reg <= crc_bit;                          // see RULE22
      if (byte_end) tx_crc_hi_reg <= ~crc_bit[15:8];
    end
  end

  // Abort waits for the current byte; a fresh edge is never lost
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || tx_rst) abort_pend_reg <= 1'b0;
    else abort_pend_reg <= abort_rise || (abort_pend_reg && !byte_end);
  end

  // ****************************************************************
  // Receive packet engine
  // ****************************************************************
  logic [6:0]  rx_hist_reg;
  logic [2:0]  rx_ones_reg;
  logic [7:0]  rx_acc_reg;
  logic [2:0]  rx_cnt_reg;
  logic        rx_inframe_reg;
  logic        rx_first_reg;
  logic [1:0]  rx_nbytes_reg;
  logic [7:0]  rx_b0_reg;
  logic [7:0]  rx_b1_reg;
  logic [7:0]  rx_b2_reg;
  logic [15:0] rx_crc_reg;
  logic [7:0]  rx_byte;
  logic        rx_flag;
  logic        rx_abort;
  logic        rx_drop;

  assign rx_flag = {FDL_RX_BIT, rx_hist_reg} == `FLAG_BYTE;
  assign rx_abort = FDL_RX_BIT && rx_ones_reg >= 3'h6;
  assign rx_drop = !FDL_RX_BIT && rx_ones_reg == 3'h5;
  assign rx_byte = {FDL_RX_BIT, rx_acc_reg[7:1]};

  // Flag hunt, destuffing and three-byte holdback that strips the check
  always_ff @(posedge SYS_CLK) begin
    rx_push_reg <= 1'b0;
    if (SYS_RST || rx_rst) begin
      rx_hist_reg <= 7'h00;
      rx_ones_reg <= 3'h0;
      rx_acc_reg <= 8'h00;
      rx_cnt_reg <= 3'h0;
      rx_inframe_reg <= 1'b0;
      rx_first_reg <= 1'b1;
      rx_nbytes_reg <= 2'h0;
      rx_crc_reg <= `CRC_INIT;
      rx_push_data_reg <= '0;
    end else if (FDL_RX_STROBE) begin
      rx_hist_reg <= {FDL_RX_BIT, rx_hist_reg[6:1]};
      rx_ones_reg <= !FDL_RX_BIT ? 3'h0 :
                     (rx_ones_reg == 3'h7) ? 3'h7 : rx_ones_reg + 3'h1;
      if (rx_abort) begin
        rx_inframe_reg <= 1'b0;                       // see RULE1
      end else if (rx_flag) begin
        if (rx_inframe_reg && rx_cnt_reg == 3'h7 && rx_nbytes_reg == 2'h3) begin
          rx_push_reg <= 1'b1;
          rx_push_data_reg <= '{open_b: rx_first_reg, close_b: 1'b1,
                                good: rx_crc_reg == `CRC_GOOD,
                                data: rx_b0_reg};     // see RULE22
        end
        rx_inframe_reg <= 1'b1;
        rx_cnt_reg <= 3'h0;
        rx_nbytes_reg <= 2'h0;
        rx_first_reg <= 1'b1;
        rx_crc_reg <= `CRC_INIT;
      end else if (rx_inframe_reg && !rx_drop) begin
        rx_acc_reg <= rx_byte;
        rx_cnt_reg <= rx_cnt_reg + 3'h1;
        if (rx_cnt_reg == 3'h7) begin
          rx_crc_reg <= crc_byte(rx_crc_reg, rx_byte);
          rx_b0_reg <= rx_b1_reg;
          rx_b1_reg <= rx_b2_reg;
          rx_b2_reg <= rx_byte;
          if (rx_nbytes_reg == 2'h3) begin
            rx_push_reg <= 1'b1;
            rx_first_reg <= 1'b0;
            rx_push_data_reg <= '{open_b: rx_first_reg, close_b: 1'b0,
                                  good: 1'b0, data: rx_b0_reg};
          end else begin
            rx_nbytes_reg <= rx_nbytes_reg + 2'h1;
          end
        end
      end
    end
  end

  // ****************************************************************
  // Code detector
  // ****************************************************************
  logic [15:0] code_win_reg;
  logic [15:0] code_nw;
  logic [5:0]  code_cand_reg;
  logic [1:0]  code_hits_reg;
  logic [5:0]  code_miss_reg;
  logic        code_present_now;
  logic [5:0]  code_val_reg;
  logic        code_match;
  logic        code_chg;

  assign code_nw = {FDL_RX_BIT, code_win_reg[15:1]};
  assign code_match = FDL_RX_STROBE && code_nw[7:0] == `CODE_ONES
                      && !code_nw[8] && !code_nw[15];

  // Two matching repeats validate; a long silence means it ceased
  always_ff @(posedge SYS_CLK) begin
    code_chg <= 1'b0;
    if (SYS_RST || code_rst) begin
      code_win_reg <= 16'h0000;
      code_cand_reg <= 6'h00;
      code_hits_reg <= 2'h0;
      code_miss_reg <= 6'h00;
      code_present_now <= 1'b0;
      code_val_reg <= 6'h00;
    end else if (FDL_RX_STROBE) begin
      code_win_reg <= code_nw;
      if (code_match) begin
        code_miss_reg <= 6'h00;
        code_cand_reg <= code_nw[14:9];
        if (code_nw[14:9] != code_cand_reg) begin
          code_hits_reg <= 2'h1;
        end else if (code_hits_reg + 2'h1 >= `CODE_HITS) begin
          code_hits_reg <= `CODE_HITS;
          code_val_reg <= code_nw[14:9];
          code_present_now <= 1'b1;
          code_chg <= !code_present_now;              // see RULE3
        end else begin
          code_hits_reg <= code_hits_reg + 2'h1;
        end
      end else if (code_miss_reg >= `CODE_MISS) begin
        code_hits_reg <= 2'h0;
        code_present_now <= 1'b0;
        code_chg <= code_present_now;                 // see RULE3
      end else begin
        code_miss_reg <= code_miss_reg + 6'h01;
      end
    end
  end

  assign RX_CODE_RD = {1'b0, code_present_now, code_val_reg};

  // ****************************************************************
  // Status registers and interrupt
  // ****************************************************************
  logic [4:0] rx_cnt_q_reg;
  logic [4:0] tx_cnt_q_reg;
  logic [1:0] tx_ev_reg;
  logic [7:0] ev   [3];
  logic [7:0] rt   [3];
  logic [7:0] lat_reg [3];
  logic [7:0] rd_reg  [3];
  logic [7:0] lmask [3];

  // Occupancy history for crossing events
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rx_cnt_q_reg <= 5'h00;
      tx_cnt_q_reg <= 5'h00;
      tx_ev_reg <= 2'h0;
    end else begin
      rx_cnt_q_reg <= rx_count;
      tx_cnt_q_reg <= tx_count;
      tx_ev_reg <= {byte_end && underrun_c, byte_end && done_c};
    end
  end

  assign ev[0] = {code_chg,
                  rx_push_reg && rx_room && rx_push_data_reg.close_b,
                  rx_push_reg && rx_room && rx_push_data_reg.open_b,
                  rx_count > `FIFO_HALF && rx_cnt_q_reg <= `FIFO_HALF,
                  rx_count != 5'h00 && rx_cnt_q_reg == 5'h00,
                  tx_count <= `FIFO_HALF && tx_cnt_q_reg > `FIFO_HALF,
                  TX_READY && tx_cnt_q_reg == 5'(`FIFO_DEPTH),
                  tx_ev_reg[0]};
  assign ev[1] = 8'h00;
  assign ev[2] = {5'h00, tx_ev_reg[1], 2'h0};
  assign rt[0] = 8'h00;
  assign rt[1] = {4'h0, rx_head.good && RX_VALID,
                  rx_head.close_b && RX_VALID,
                  rx_head.open_b && RX_VALID, !RX_VALID};  // see RULE15
  assign rt[2] = {5'h00, 1'b0, !TX_READY, tx_count == 5'h00}; // see RULE6
  assign lmask[0] = `LAT_EVENT;
  assign lmask[1] = `LAT_RX;
  assign lmask[2] = `LAT_TX;

  // Write-mask capture; an event in the clearing cycle survives
  for (genvar g = 0; g < 3; g++) begin : g_stat
    logic [7:0] clr;
    assign clr = (STAT_WR && STAT_SEL == 2'(g)) ? STAT_MASK : 8'h00;
    always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
        lat_reg[g] <= 8'h00;
        rd_reg[g] <= 8'h00;
      end else begin
        lat_reg[g] <= ((lat_reg[g] & ~clr) | ev[g]) & lmask[g]; // see RULE5
        rd_reg[g] <= (((rd_reg[g] & ~clr)                       // see RULE8
                      | (lat_reg[g] & clr)) & lmask[g])         // see RULE7
                     | (rt[g] & ~lmask[g]);                     // see RULE6
      end
    end
  end

  assign LINK_EVENT_RD = rd_reg[0];
  assign RX_STATUS_RD = rd_reg[1];
  assign TX_STATUS_RD = rd_reg[2];

  // Interrupt follows unread, unmasked link events
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) INT_N <= 1'b1;
    else INT_N <= ~|(lat_reg[0] & EVENT_MASK);  // see RULE10 see RULE11
  end

endmodule : fdl_link_ctrl

`default_nettype wire

// ==== shared/fdl_cfg.svh ====
// Constants of the data link packet and code controller.
// Assumes inclusion by bare name; holds definitions only.
`ifndef FDL_CFG_SVH
`define FDL_CFG_SVH

// Fixed line bytes
`define FLAG_BYTE    8'h7E
`define ABORT_BYTE   8'hFE
`define IDLE_BYTE    8'hFF
`define CODE_ONES    8'hFF

// Frame check sequence, reflected form, init and good residue
`define CRC_POLY     16'h8408
`define CRC_INIT     16'hFFFF
`define CRC_GOOD     16'hF0B8

// Buffer geometry and halfway point
`define FIFO_DEPTH   16
`define FIFO_HALF    5'h08

// Code detector: matches to validate, bits of silence to cease
`define CODE_HITS    2'h2
`define CODE_MISS    6'h20

// Status register select and latched-bit layouts
`define SEL_EVENT    2'h0
`define SEL_RX       2'h1
`define SEL_TX       2'h2
`define LAT_EVENT    8'hFF
`define LAT_RX       8'h00
`define LAT_TX       8'h04

`endif

// ==== shared/fdl_pkg.sv ====
// Types shared by the data link controller files.
// Assumes fdl_cfg.svh supplies the numeric constants.
package fdl_pkg;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_OPEN,
    TX_DATA,
    TX_CRC_HI,
    TX_CLOSE
  } tx_state_t;

  // Transmit buffer entry: byte plus end-of-message mark
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } tx_entry_t;

  // Receive buffer entry: byte plus packet position and verdict
  typedef struct packed {
    logic       open_b;
    logic       close_b;
    logic       good;
    logic [7:0] data;
  } rx_entry_t;

endpackage : fdl_pkg

// ==== rtl/fdl_byte_fifo.sv ====
// Synchronous flip-flop FIFO with valid/ready on both sides.
// Assumes one clock, synchronous reset, DEPTH a power of two.
`timescale 1ns/1ps
`default_nettype none

module fdl_byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   flush,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  output logic [$clog2(DEPTH):0]      count
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  // Full and empty come straight from the count, so never lie
  assign in_ready  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_reg];
  assign count     = cnt_reg;

  // Storage, one flip-flop word per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (push && wr_reg == AW'(i)) begin
        mem_reg[i] <= in_data;
      end
    end
  end

  // Pointers and occupancy; flush wins over any transfer
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule : fdl_byte_fifo

`default_nettype wire

// ==== dv/fdl_link_ctrl_asserts.sv ====
// Port checks of the link controller.
// Assumes a bind onto fdl_link_ctrl.
`timescale 1ns/1ps
`default_nettype none
module fdl_link_ctrl_asserts (
  input wire logic       SYS_CLK,
  input wire logic       SYS_RST,
  input wire logic       STAT_WR,
  input wire logic [1:0] STAT_SEL,
  input wire logic [7:0] STAT_MASK,
  input wire logic [7:0] EVENT_MASK,
  input wire logic [7:0] LINK_EVENT_RD,
  input wire logic [7:0] TX_STATUS_RD,
  input wire logic       INT_N,
  input wire logic       TX_READY,
  input wire logic       ABORT_SEND_BIT,
  input wire logic       FDL_TX_STROBE,
  input wire logic       FDL_TX_BIT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // ********
  // Checks
  // ********
  property p_keep; STAT_WR && STAT_SEL == 2'h0 && STAT_MASK == 8'h00
    |=> $stable(LINK_EVENT_RD); endproperty
  a_keep: assert property (p_keep) else $error("kept");
  property p_sel3; STAT_WR && STAT_SEL == 2'h3 |=> $stable(LINK_EVENT_RD);
    endproperty
  a_sel3: assert property (p_sel3) else $error("sel");
  property p_full; !$past(SYS_RST) |-> TX_STATUS_RD[1] == !$past(TX_READY);
    endproperty
  a_full: assert property (p_full) else $error("full");
  property p_void; TX_STATUS_RD[0] |-> TX_READY; endproperty
  a_void: assert property (p_void) else $error("void");
  property p_excl; !(TX_STATUS_RD[0] && TX_STATUS_RD[1]); endproperty
  a_excl: assert property (p_excl) else $error("excl");
  property p_int; $past(EVENT_MASK) == 8'h00 |-> INT_N; endproperty
  a_int: assert property (p_int) else $error("irq");
  property p_abort; $rose(ABORT_SEND_BIT) |-> ##[1:4] TX_READY; endproperty
  a_abort: assert property (p_abort) else $error("abort");
  property p_line; !$past(FDL_TX_STROBE) |-> $stable(FDL_TX_BIT); endproperty
  a_line: assert property (p_line) else $error("line");
endmodule : fdl_link_ctrl_asserts
`default_nettype wire

// ==== dv/fdl_link_partner.sv ====
// Framer side: bit strobes and a line loopback.
// Assumes the controller clock.
`timescale 1ns/1ps
`default_nettype none
module fdl_link_partner (
  input  wire logic clk,
  input  wire logic slow,
  output logic      tx_strobe = 1'b0,
  input  wire logic tx_bit,
  output logic      rx_strobe = 1'b0,
  output logic      rx_bit = 1'b0
);
  logic [2:0] cnt_reg = 3'h0;
  logic       take_reg = 1'b0;
  // ********
  // Strobes
  // ********
  // A bit per 4 cycles, per 8 when slow; between strobes rx shows junk
  always @(posedge clk) begin
    cnt_reg   <= cnt_reg + 3'h1;
    tx_strobe <= cnt_reg == 3'h0 || (!slow && cnt_reg == 3'h4);
    take_reg  <= tx_strobe;
    rx_strobe <= take_reg;
    rx_bit    <= take_reg ? tx_bit : !rx_bit;
  end
endmodule : fdl_link_partner
`default_nettype wire

// ==== dv/fdl_link_ctrl_tb_top.sv ====
// Bench: loopback packet, fill and abort, status, codes.
// Assumes the partner loops the line back.
`timescale 1ns/1ps
`default_nettype none
module fdl_link_ctrl_tb_top;
  logic SYS_CLK = 0, SYS_RST = 1, CODE_RESET_BIT = 0, TX_RESET_BIT = 0,
    RX_PACKET_RESET_BIT = 0, ABORT_SEND_BIT = 0, IDLE_SELECT = 0,
    LAST_BYTE_MARK = 0, STUFF_DISABLE = 0, CRC_DISABLE = 0, CTRL_ENABLE = 0,
    SEND_CODE_BIT = 0, STAT_WR = 0, TX_WR = 0, RX_RD = 0, slow = 0, wr_d = 0,
    INT_N, TX_READY, RX_VALID, FDL_TX_STROBE, FDL_TX_BIT, FDL_RX_STROBE,
    FDL_RX_BIT;
  logic [1:0] STAT_SEL = 0, sel_d = 0;
  logic [5:0] TX_CODE = 0;
  logic [7:0] STAT_MASK = 0, EVENT_MASK = 0, TX_WR_DATA = 0, LINK_EVENT_RD,
    RX_STATUS_RD, TX_STATUS_RD, RX_CODE_RD, RX_DATA, rq[$], sq[$];
  int fail_count = 0, compares = 0, n;
  fdl_link_ctrl dut_u (.*);
  fdl_link_partner far_u (.clk(SYS_CLK), .slow(slow),
    .tx_strobe(FDL_TX_STROBE), .tx_bit(FDL_TX_BIT),
    .rx_strobe(FDL_RX_STROBE), .rx_bit(FDL_RX_BIT));
  // ********
  // Helpers
  // ********
  initial forever #25 SYS_CLK = ~SYS_CLK;
  // Watchdog far beyond the few thousand cycles the tests need
  initial begin
    #1000000;
    fail_count++;
    end_of_test();
  end
  task automatic chk(string w, logic [7:0] e, logic [7:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic tk(int k = 1);
    repeat (k) @(posedge SYS_CLK);
    #1;
  endtask : tk
  task automatic st(logic [1:0] s, logic [7:0] m, logic [7:0] e);
    sq.push_back(e);
    {STAT_SEL, STAT_MASK, STAT_WR} = {s, m, 1'b1};
    tk();
    STAT_WR = 0;
    tk(2);
  endtask : st
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // Each result takes the oldest note; a read value shows one edge on
  always @(posedge SYS_CLK) begin
    if (wr_d && sel_d != 2'h3)
      chk("stat", sq.pop_front(), sel_d[1] ? TX_STATUS_RD : LINK_EVENT_RD);
    if (RX_VALID && RX_RD && rq.size() == 1)
      chk("rx stat", 8'h0C, RX_STATUS_RD);
    if (RX_VALID && RX_RD)
      chk("rx", rq.size() ? rq.pop_front() : ~RX_DATA, RX_DATA);
    wr_d <= STAT_WR;
    sel_d <= STAT_SEL;
  end
  initial begin
    void'($urandom(61));
    tk(16);
    {SYS_RST, CTRL_ENABLE, RX_PACKET_RESET_BIT} = 3'h3;
    EVENT_MASK = 8'h40;
    for (int i = 0; i < 12; i++) begin
      {TX_WR, LAST_BYTE_MARK, TX_WR_DATA} = {1'b1, i == 11, 8'($urandom)};
      rq.push_back(TX_WR_DATA);
      tk();
    end
    {TX_WR, LAST_BYTE_MARK} = 0;
    for (n = 0; INT_N !== 1'b0 && n < 4000; n++) tk();
    chk("irq", 8'h00, {7'h00, INT_N});
    for (n = 0; rq.size() && n < 400; n++) begin
      RX_RD = (rq.size() > 1 || n > 300) && 1'($urandom);
      tk();
    end
    RX_RD = 0;
    chk("rx left", 8'h00, 8'(rq.size()));
    st(0, 8'h40, 8'h40);
    chk("irq", 8'h01, {7'h00, INT_N});
    st(2, 8'h04, 8'h01);
    $display("packet test done");
    {slow, IDLE_SELECT, STAT_SEL, STAT_WR, TX_WR} = 6'h3F; // select 3 refused
    for (n = 0; TX_READY === 1'b1 && n < 24; n++) begin
      TX_WR_DATA = 8'($urandom);
      tk();
    end
    {STAT_WR, TX_WR, ABORT_SEND_BIT} = 3'h1;
    chk("fill", 8'h01, {7'h00, n inside {16, 17}});
    tk(4);
    chk("ready", 8'h01, {7'h00, TX_READY});
    tk(600);
    st(0, 8'hFF, 8'h3F);
    st(0, 8'h00, 8'h3F);
    st(0, 8'hFF, 8'h00);
    $display("fill test done");
    {slow, SEND_CODE_BIT, TX_CODE} = {2'h1, 6'($urandom % 63)};
    tk(1500);
    chk("code", {2'h1, TX_CODE}, RX_CODE_RD);
    st(0, 8'h80, 8'h80);
    SEND_CODE_BIT = 0;
    tk(1500);
    chk("code", {2'h0, TX_CODE}, RX_CODE_RD);
    st(0, 8'h80, 8'h80);
    $display("code test done");
    end_of_test();
  end
endmodule : fdl_link_ctrl_tb_top
bind fdl_link_ctrl fdl_link_ctrl_asserts chk_u (.*);
`default_nettype wire
